// *** core/dtc_top.sv ***
// Purpose: Dual timer/counter with Wishbone register access
// Assumes: Count and gate pins synchronous to clock
// Notes: Registers answer with ack one cycle after the request
`timescale 1ns/1ps
module dtc_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dtc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Count and gate pins
    input wire logic first_count_pin_in,
    input wire logic second_count_pin_in,
    input wire logic first_gate_pin,
    input wire logic second_gate_pin,
    output logic first_count_pin_out,
    output logic first_count_pin_oe,
    output logic second_count_pin_out,
    output logic second_count_pin_oe,
    // Interrupt service entry
    input wire logic first_service_enter,
    input wire logic second_service_enter,
    // Status outputs
    output logic first_timer_irq,
    output logic second_timer_irq,
    output logic baud_tick
);
    import dtc_pkg::*;

    logic [7:0] timer_control_register;
    logic [7:0] timer_mode_register;
    logic [7:0] clock_control;
    logic [7:0] pin_setting_and_timer_output;
    logic prescale_tick;
    logic first_pin_q;
    logic second_pin_q;
    logic first_fall;
    logic second_fall;
    logic [3:0] mode0;
    logic [3:0] mode1;
    logic first_split;
    logic first_run;
    logic second_run;
    logic first_overflow_flag;
    logic second_overflow_flag;
    logic first_go;
    logic second_go;
    logic first_tick;
    logic second_tick;
    logic split_high_tick;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rdata;
    logic first_ovf;
    logic second_ovf;
    logic first_flag_set;
    logic second_flag_set;

    dtc_tick_if first_if ();
    dtc_tick_if second_if ();

    // Nibble of mode register for one timer
    function automatic logic [3:0] nib(input logic [7:0] r, input logic hi);
        nib = hi ? r[7:4] : r[3:0];
    endfunction

    // Timer source enable from select and pin edge
    function automatic logic src_tick(input logic [3:0] m,
                                      input logic direct,
                                      input logic pre,
                                      input logic fall);
        if (m[MOD_COUNTER]) begin
            src_tick = fall;
        end else begin
            src_tick = direct ? 1'b1 : pre;
        end
    endfunction

    assign mode0 = nib(timer_mode_register, 1'b0);
    assign mode1 = nib(timer_mode_register, 1'b1);
    assign first_split = (mode0[1:0] == MODE_SPLIT);
    assign first_run = timer_control_register[CTL_T0_RUN];
    assign second_run = timer_control_register[CTL_T1_RUN];
    assign first_overflow_flag = timer_control_register[CTL_T0_FLAG];
    assign second_overflow_flag = timer_control_register[CTL_T1_FLAG];

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[ADDR_W-1:2];
    assign wbyte = wb_dat_i[7:0];

    dtc_prescaler u_pre (
        .clock(clock),
        .reset_n(reset_n),
        .tick(prescale_tick)
    );

    // Falling edge on count pins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_pin_q <= 1'b1;
            second_pin_q <= 1'b1;
        end else begin
            first_pin_q <= first_count_pin_in;
            second_pin_q <= second_count_pin_in;
        end
    end
    assign first_fall = first_pin_q && !first_count_pin_in;
    assign second_fall = second_pin_q && !second_count_pin_in;

    // Run and gate qualification
    assign first_go = first_run && (!mode0[MOD_GATE] || first_gate_pin);
    // Second timer runs free of its run bit while shared
    assign second_go = (first_split ? 1'b1 : second_run) &&
                       (!mode1[MOD_GATE] || second_gate_pin);

    // Source selection
    assign first_tick = first_go &&
        src_tick(mode0, clock_control[CKC_T0_SEL], prescale_tick, first_fall);
    assign second_tick = second_go &&
        src_tick(mode1, clock_control[CKC_T1_SEL], prescale_tick,
                 second_fall);
    // Split high byte counts clock or prescaler ticks, never pin edges
    assign split_high_tick = second_run &&
        (clock_control[CKC_T0_SEL] ? 1'b1 : prescale_tick);

    dtc_unit u_first (
        .clock(clock),
        .reset_n(reset_n),
        .mode(mode0[1:0]),
        .split_capable(1'b1),
        .low_tick(first_tick),
        .high_tick(split_high_tick),
        .wr_low(wr && idx == IDX_T0_LOW),
        .wr_high(wr && idx == IDX_T0_HIGH),
        .wdata(wbyte),
        .tk(first_if.unit)
    );

    dtc_unit u_second (
        .clock(clock),
        .reset_n(reset_n),
        .mode(mode1[1:0]),
        .split_capable(1'b0),
        .low_tick(second_tick),
        .high_tick(1'b0),
        .wr_low(wr && idx == IDX_T1_LOW),
        .wr_high(wr && idx == IDX_T1_HIGH),
        .wdata(wbyte),
        .tk(second_if.unit)
    );

    // Overflow of the active counter for each timer
    assign first_ovf = first_if.main_ovf || first_if.low_ovf;
    assign second_ovf = second_if.main_ovf;
    assign first_flag_set = first_ovf;
    // Shared: second flag belongs to split high byte
    assign second_flag_set = first_split ? first_if.high_ovf : second_ovf;

    // Control register: flags, run bits; set beats clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_control_register <= RST_BYTE;
        end else begin
            if (wr && idx == IDX_CONTROL) begin
                timer_control_register <= wbyte & CTL_MASK;
            end else begin
                if (first_service_enter) begin
                    timer_control_register[CTL_T0_FLAG] <= 1'b0;
                end
                if (second_service_enter) begin
                    timer_control_register[CTL_T1_FLAG] <= 1'b0;
                end
            end
            if (first_flag_set) begin
                timer_control_register[CTL_T0_FLAG] <= 1'b1;
            end
            if (second_flag_set) begin
                timer_control_register[CTL_T1_FLAG] <= 1'b1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_mode_register <= RST_BYTE;
            clock_control <= RST_BYTE;
            pin_setting_and_timer_output <= RST_BYTE;
        end else if (wr) begin
            if (idx == IDX_MODE) begin
                timer_mode_register <= wbyte;
            end
            if (idx == IDX_CLOCK_CONTROL) begin
                clock_control <= wbyte & CKC_MASK;
            end
            if (idx == IDX_PIN_SETTING) begin
                pin_setting_and_timer_output <= wbyte & PIN_MASK;
            end
        end
    end

    // Timer output pins toggle on overflow
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_count_pin_out <= 1'b0;
            second_count_pin_out <= 1'b0;
            first_count_pin_oe <= 1'b0;
            second_count_pin_oe <= 1'b0;
        end else begin
            first_count_pin_oe <= pin_setting_and_timer_output[PIN_T0_OE];
            second_count_pin_oe <= pin_setting_and_timer_output[PIN_T1_OE];
            if (pin_setting_and_timer_output[PIN_T0_OE] && first_ovf) begin
                first_count_pin_out <= !first_count_pin_out;
            end
            if (pin_setting_and_timer_output[PIN_T1_OE] && second_ovf) begin
                second_count_pin_out <= !second_count_pin_out;
            end
        end
    end

    // Interrupt requests and baud clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_timer_irq <= 1'b0;
            second_timer_irq <= 1'b0;
            baud_tick <= 1'b0;
        end else begin
            first_timer_irq <= first_overflow_flag;
            second_timer_irq <= second_overflow_flag;
            // Second timer only, flag-free while shared
            baud_tick <= second_ovf;
        end
    end

    // Read mux
    always_comb begin
        case (idx)
            IDX_CONTROL: rdata = timer_control_register;
            IDX_MODE: rdata = timer_mode_register;
            IDX_T0_LOW: rdata = first_if.low_q;
            IDX_T1_LOW: rdata = second_if.low_q;
            IDX_T0_HIGH: rdata = first_if.high_q;
            IDX_T1_HIGH: rdata = second_if.high_q;
            IDX_CLOCK_CONTROL: rdata = clock_control;
            IDX_PIN_SETTING: rdata = pin_setting_and_timer_output;
            default: rdata = RST_BYTE;
        endcase
    end

    // Wishbone answer, one cycle after request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, rdata};
            end
        end
    end
endmodule

// *** core/dtc_pkg.sv ***
// Purpose: Shared constants for the dual timer/counter block
// Assumes: 8-bit registers on a classic Wishbone slave, word aligned
// Notes: Byte address is four times the register index
package dtc_pkg;
    localparam int ADDR_W = 10;
    // Register indices
    localparam logic [7:0] IDX_CONTROL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_T0_LOW = 8'h8A;
    localparam logic [7:0] IDX_T1_LOW = 8'h8B;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8C;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8D;
    localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h8E;
    localparam logic [7:0] IDX_PIN_SETTING = 8'hB5;
    localparam logic [7:0] IDX_SERVICE_ACK = 8'hF0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Control register fields
    localparam int CTL_T1_FLAG = 7;
    localparam int CTL_T1_RUN = 6;
    localparam int CTL_T0_FLAG = 5;
    localparam int CTL_T0_RUN = 4;
    localparam logic [7:0] CTL_MASK = 8'hF0;
    // Mode register nibble fields
    localparam int MOD_GATE = 3;
    localparam int MOD_COUNTER = 2;
    localparam int MOD_SHIFT_T1 = 4;
    // Clock control fields
    localparam int CKC_T1_SEL = 4;
    localparam int CKC_T0_SEL = 3;
    localparam logic [7:0] CKC_MASK = 8'h5A;
    // Pin setting fields
    localparam int PIN_T1_OE = 3;
    localparam int PIN_T0_OE = 2;
    localparam logic [7:0] PIN_MASK = 8'h8D;
    // Prescaler
    localparam int PRESCALE_DIV = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
    // Mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [4:0] LOW5_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage

// *** core/dtc_tick_if.sv ***
// Purpose: Carries counter bytes and overflow pulses between modules
// Assumes: One clock domain
// Notes: Driven by the unit, read by the top
`timescale 1ns/1ps
interface dtc_tick_if;
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic low_ovf;
    logic high_ovf;
    logic main_ovf;
    modport unit (output low_q, high_q, low_ovf, high_ovf, main_ovf);
    modport top (input low_q, high_q, low_ovf, high_ovf, main_ovf);
endinterface

// *** core/dtc_unit.sv ***
// Purpose: One timer's counting registers in all four modes
// Assumes: Enables are one-cycle pulses on the system clock
// Notes: Split flag selects the first timer's two-byte arrangement
`timescale 1ns/1ps
module dtc_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Configuration
    input wire logic [1:0] mode,
    input wire logic split_capable,
    // Count enables
    input wire logic low_tick,
    input wire logic high_tick,
    // Software writes
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    // Results
    dtc_tick_if.unit tk
);
    import dtc_pkg::*;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic main_ovf_c;
    logic high_ovf_c;
    logic low_ovf_c;
    logic halted;

    assign halted = (mode == MODE_SPLIT) && !split_capable;

    always_comb begin
        next_low = tk.low_q;
        next_high = tk.high_q;
        main_ovf_c = 1'b0;
        high_ovf_c = 1'b0;
        low_ovf_c = 1'b0;
        case (mode)
            MODE_13BIT: begin
                if (low_tick) begin
                    // Upper three low bits held
                    next_low = {tk.low_q[7:5], tk.low_q[4:0] + 5'h01};
                    if (tk.low_q[4:0] == LOW5_MAX) begin
                        next_high = tk.high_q + 8'h01;
                        // 1FFF to 0000
                        main_ovf_c = (tk.high_q == BYTE_MAX);
                    end
                end
            end
            MODE_16BIT: begin
                if (low_tick) begin
                    next_low = tk.low_q + 8'h01;
                    if (tk.low_q == BYTE_MAX) begin
                        next_high = tk.high_q + 8'h01;
                        main_ovf_c = (tk.high_q == BYTE_MAX);
                    end
                end
            end
            MODE_RELOAD: begin
                if (low_tick) begin
                    if (tk.low_q == BYTE_MAX) begin
                        // High byte left intact
                        next_low = tk.high_q;
                        main_ovf_c = 1'b1;
                    end else begin
                        next_low = tk.low_q + 8'h01;
                    end
                end
            end
            default: begin
                if (!halted) begin
                    // Two independent bytes
                    if (low_tick) begin
                        next_low = tk.low_q + 8'h01;
                        low_ovf_c = (tk.low_q == BYTE_MAX);
                    end
                    if (high_tick) begin
                        next_high = tk.high_q + 8'h01;
                        high_ovf_c = (tk.high_q == BYTE_MAX);
                    end
                end
            end
        endcase
        if (wr_low) begin
            next_low = wdata;
        end
        if (wr_high) begin
            next_high = wdata;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tk.low_q <= RST_BYTE;
            tk.high_q <= RST_BYTE;
            tk.low_ovf <= 1'b0;
            tk.high_ovf <= 1'b0;
            tk.main_ovf <= 1'b0;
        end else begin
            tk.low_q <= next_low;
            tk.high_q <= next_high;
            tk.low_ovf <= low_ovf_c;
            tk.high_ovf <= high_ovf_c;
            tk.main_ovf <= main_ovf_c;
        end
    end
endmodule

// *** core/dtc_prescaler.sv ***
// Purpose: Divide-by-twelve enable for the timer clock source
// Assumes: Runs from reset onward
// Notes: Pulse lasts one system clock
`timescale 1ns/1ps
module dtc_prescaler (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Enable out
    output logic tick
);
    import dtc_pkg::*;
    logic [3:0] count;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= 4'h0;
            tick <= 1'b0;
        end else begin
            tick <= (count == PRESCALE_LAST);
            if (count == PRESCALE_LAST) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end
endmodule

// *** verif/dtc_top_sva.sv ***
// Purpose: Port assertions for the dual timer block
// Assumes: One clock, active-low async reset
// Notes: Bound into every dtc_top
`timescale 1ns/1ps
module dtc_top_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dtc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and status
    input wire logic first_count_pin_oe,
    input wire logic second_count_pin_oe,
    input wire logic first_service_enter,
    input wire logic second_service_enter,
    input wire logic first_timer_irq,
    input wire logic second_timer_irq,
    input wire logic baud_tick
);
    import dtc_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] idx;
    logic rd_ack;
    logic wr_ack;
    logic wr_pin;
    logic mapped;
    assign idx = wb_adr_i[9:2];
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign wr_ack = wb_ack_o && wb_we_i;
    assign wr_pin = wr_ack && wb_sel_i[0] && idx == IDX_PIN_SETTING;
    assign mapped = (idx >= IDX_CONTROL && idx <= IDX_CLOCK_CONTROL)
        || idx == IDX_PIN_SETTING;
    chk_ack_taken:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_read_upper:
        assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_unmapped_zero:
        assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_first_oe:
        assert property (wr_pin
        |=> first_count_pin_oe == $past(wb_dat_i[PIN_T0_OE]))
        else $error("first output enable wrong");
    chk_second_oe:
        assert property (wr_pin
        |=> second_count_pin_oe == $past(wb_dat_i[PIN_T1_OE]))
        else $error("second output enable wrong");
    chk_first_clear:
        assert property ($fell(first_timer_irq)
        |-> $past(first_service_enter, 2) || $past(wr_ack))
        else $error("first irq fell without cause");
    chk_second_clear:
        assert property ($fell(second_timer_irq)
        |-> $past(second_service_enter, 2) || $past(wr_ack))
        else $error("second irq fell without cause");
    cover property (wr_pin);
    cover property ($fell(first_timer_irq));
    cover property (baud_tick);
endmodule
bind dtc_top dtc_top_sva u_dtc_top_sva (.clock, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .first_count_pin_oe, .second_count_pin_oe,
    .first_service_enter, .second_service_enter, .first_timer_irq,
    .second_timer_irq, .baud_tick);

// *** verif/dtc_pins.sv ***
// Purpose: External gate and count pin source for the timer block
// Assumes: Pins change just after a rising clock edge
// Notes: Count pins idle high, so each pulse gives one falling edge
`timescale 1ns/1ps
module dtc_pins (
    // Clock
    input wire logic clock,
    // Pins toward the block
    output logic [1:0] count_pin,
    output logic [1:0] gate_pin
);
    initial begin
        count_pin = 2'h3;
        gate_pin = 2'h0;
    end
    // Gate open over k pulses plus n sampling edges
    task automatic drive(input int t, input int n, input int k);
        @(posedge clock);
        gate_pin[t] <= 1'b1;
        repeat (k) begin
            count_pin[t] <= 1'b0;
            repeat (2) @(posedge clock);
            count_pin[t] <= 1'b1;
            repeat (2) @(posedge clock);
        end
        repeat (n) @(posedge clock);
        gate_pin <= 2'h0;
    endtask
endmodule

// *** verif/test_dual_timer_counter_modes.sv ***
// Purpose: Self-checking bench for the dual timer block
// Assumes: Gate windows give exact tick counts
// Notes: Expected counts come from the integer model below
`timescale 1ns/1ps
module test_dual_timer_counter_modes;
    import dtc_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic ack;
    logic baud;
    logic [1:0] svc = 2'h0;
    logic [1:0] cpin;
    logic [1:0] gpin;
    logic [1:0] pin;
    logic [1:0] pout;
    logic [1:0] poe;
    logic [1:0] irq;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'h2abc;
    int cycles = 0;
    int bauds = 0;
    int tg [2] = '{0, 0};
    int lo, hi, ov;
    logic [7:0] ridx [4] = '{IDX_CLOCK_CONTROL, IDX_PIN_SETTING,
        IDX_MODE, 8'h10};
    logic [7:0] rmsk [4] = '{CKC_MASK, PIN_MASK, 8'hFF, 8'h00};
    always #10 clock = ~clock;
    // Shared count pin level
    assign pin = (poe & pout) | (~poe & cpin);
    dtc_top u_dtc_top (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .first_count_pin_in(pin[0]), .second_count_pin_in(pin[1]),
        .first_gate_pin(gpin[0]), .second_gate_pin(gpin[1]),
        .first_count_pin_out(pout[0]), .first_count_pin_oe(poe[0]),
        .second_count_pin_out(pout[1]), .second_count_pin_oe(poe[1]),
        .first_service_enter(svc[0]), .second_service_enter(svc[1]),
        .first_timer_irq(irq[0]), .second_timer_irq(irq[1]),
        .baud_tick(baud));
    dtc_pins u_dtc_pins (.clock(clock), .count_pin(cpin), .gate_pin(gpin));
    always @(pout[0]) if (reset_n === 1'b1) tg[0]++;
    always @(pout[1]) if (reset_n === 1'b1) tg[1]++;
    always @(posedge clock) begin
        cycles++;
        if (baud === 1'b1) bauds++;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_n(input int g, input int e);
        tests_run++;
        if (g != e) begin
            miscompares++;
            $display("ERROR at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'($random(seed)), d};
        do @(posedge clock); while (ack !== 1'b1);
        rq = rdat;
        cyc <= 1'b0;
    endtask
    function automatic void model(input int m, input int n);
        int w;
        ov = 0;
        w = m ? 256 : 32;
        repeat (n) begin
            if (m == 2) begin
                lo++;
                if (lo == 256) begin
                    lo = hi;
                    ov++;
                end
            end else begin
                lo = (lo & (256 - w)) | ((lo + 1) % w);
                if (lo % w == 0) hi = (hi + 1) % 256;
                if (lo % w == 0 && hi == 0) ov++;
            end
        end
    endfunction
    // One gated run of timer t: mode m, direct clock d, k pin edges
    task automatic run(input int t, input int m, input int d, input int k,
                       input int n, input logic [7:0] l0,
                       input logic [7:0] h0);
        logic [7:0] fl;
        logic [7:0] mk;
        fl = 8'h20 << (2 * t);
        mk = m == 0 ? 8'h1F : 8'hFF;
        bus(1, IDX_PIN_SETTING, k ? 8'h00 : 8'h0C);
        bus(1, IDX_MODE, 8'((8 | m | (k ? 4 : 0)) << (4 * t)));
        bus(1, IDX_CLOCK_CONTROL, 8'(d << (3 + t)));
        bus(1, IDX_T0_LOW + 8'(t), l0);
        bus(1, IDX_T0_HIGH + 8'(t), h0);
        bus(1, IDX_CONTROL, fl >> 1);
        tg = '{0, 0};
        bauds = 0;
        u_dtc_pins.drive(t, n, k);
        lo = l0;
        hi = h0;
        model(m, k ? k : (d ? n : n / 12));
        bus(0, IDX_T0_LOW + 8'(t), 8'h00);
        chk(rq & mk, lo & mk);
        bus(0, IDX_T0_HIGH + 8'(t), 8'h00);
        chk(rq, hi);
        bus(0, IDX_CONTROL, 8'h00);
        chk(rq & fl, ov ? fl : 8'h00);
        chk_n(bauds, t ? ov : 0);
        if (!k) chk_n(tg[t], ov);
        svc[t] <= 1'b1;
        @(posedge clock);
        svc[t] <= 1'b0;
        bus(0, IDX_CONTROL, 8'h00);
        chk(rq & fl, 8'h00);
        bus(1, IDX_CONTROL, 8'h00);
        $display("run timer %0d mode %0d done", t, m);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(0, ridx[i], 8'h00);
            chk(rq, 32'h0);
            bus(1, ridx[i], 8'hFF);
            bus(0, ridx[i], 8'h00);
            chk(rq, {24'h0, rmsk[i]});
            bus(1, ridx[i], 8'h00);
        end
        sel <= 4'h0;
        bus(1, IDX_MODE, 8'h5A);
        sel <= 4'hF;
        bus(0, IDX_MODE, 8'h00);
        chk(rq, 32'h0);
        bus(1, IDX_CONTROL, 8'hA0);
        repeat (2) @(posedge clock);
        chk({30'h0, irq}, 32'h3);
        svc <= 2'h3;
        @(posedge clock);
        svc <= 2'h0;
        bus(0, IDX_CONTROL, 8'h00);
        chk(rq, 32'h0);
        $display("register test done");
        for (int t = 0; t < 2; t++) begin
            run(t, 0, 1, 0, 5, 8'hFD, 8'hFF);
            run(t, 1, 1, 0, 5, 8'hFD, 8'hFF);
            run(t, 2, 1, 0, 40, 8'($random(seed)) | 8'hF0, 8'hF0);
            run(t, 1, 0, 0, 120, 8'($random(seed)), 8'hFF);
            run(t, 1, 1, 4, 4, 8'hFE, 8'hFF);
        end
        bus(1, IDX_MODE, 8'hB0);
        bus(1, IDX_T1_LOW, 8'h55);
        bus(1, IDX_CONTROL, 8'h40);
        u_dtc_pins.drive(1, 30, 0);
        bus(0, IDX_T1_LOW, 8'h00);
        chk(rq, 32'h55);
        bus(1, IDX_MODE, 8'h33);
        bus(1, IDX_CLOCK_CONTROL, 8'h08);
        bus(1, IDX_T0_LOW, 8'hFE);
        bus(1, IDX_T0_HIGH, 8'hFE);
        bus(1, IDX_CONTROL, 8'h50);
        repeat (8) @(posedge clock);
        bus(0, IDX_CONTROL, 8'h00);
        chk(rq, 32'hF0);
        bus(1, IDX_CONTROL, 8'h00);
        bus(1, IDX_T1_LOW, 8'hFF);
        bus(1, IDX_T1_HIGH, 8'hFF);
        bus(1, IDX_CLOCK_CONTROL, 8'h18);
        bauds = 0;
        bus(1, IDX_MODE, 8'h23);
        repeat (20) @(posedge clock);
        chk_n(bauds > 10, 1);
        bus(0, IDX_CONTROL, 8'h00);
        chk(rq, 32'h0);
        bus(1, IDX_MODE, 8'h00);
        $display("split mode test done");
        conclude();
    end
endmodule
